// ---- src/flash_ctl_pkg.sv ----
// constants, types and command codes shared by the flash erase controller
//
// Functional notes
// - accelerate only for bypass two-cycle programs
// - host suspends erase; repeated suspends ignored
// - chip erase is six ordered writes
// - sector erase sixth write carries sector
// - extra sectors within fifty microsecond gaps
// - host resumes erase; repeated resumes ignored
// - bypass program is A0 then address data
package flash_ctl_pkg;
    // ------------------------------------------------------------------
    // command codes and unlock addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_UNLOCK1   = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
    localparam logic [7:0]  CMD_SETUP     = 8'h80;
    localparam logic [7:0]  CMD_CHIP      = 8'h10;
    localparam logic [7:0]  CMD_SECTOR    = 8'h30;
    localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
    localparam logic [7:0]  CMD_RESUME    = 8'h30;
    localparam logic [7:0]  CMD_BYP_PROG  = 8'hA0;
    localparam logic [23:0] ADDR_UNLOCK1  = 24'h000555;
    localparam logic [23:0] ADDR_UNLOCK2  = 24'h0002AA;
    localparam int          SECTOR_LSB    = 15;

    // ------------------------------------------------------------------
    // bus timing, in ns, and derived 100 MHz cycle counts
    // ------------------------------------------------------------------
    localparam int CLK_NS        = 10;
    localparam int WE_LOW_NS     = 50;
    localparam int WE_HIGH_NS    = 30;
    localparam int ERASE_WIN_US  = 50;
    localparam int GAP_MAX_NS    = 20000;  // well inside the window
    localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC   = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_MAX_CYC   = GAP_MAX_NS / CLK_NS;
    localparam int CNT_W         = 16;
    localparam int SYNC_STAGES   = 2;      // read data crosses two flops

    // ------------------------------------------------------------------
    // wishbone register map (byte addresses) and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam int         STAT_BUSY  = 0;
    localparam int         STAT_ACC   = 1;

    // host operation codes written to REG_CMD
    typedef enum logic [2:0] {
        OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_ADD_SECTOR, OP_SUSPEND,
        OP_RESUME, OP_BYP_PROGRAM, OP_READ, OP_NONE
    } op_t;

    // one write or read cycle on the flash bus
    typedef struct packed {
        logic        rd;
        logic [23:0] addr;
        logic [15:0] data;
    } flash_cycle_t;
endpackage : flash_ctl_pkg

// ---- src/flash_erase_ctl.sv ----
// host-side controller issuing erase, suspend and bypass program cycles
//
// Implementation choices: the Wishbone slave port and the address map.
module flash_erase_ctl (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic      [23:0] FL_ADDR,
    output logic      [15:0] FL_DQ_O,
    output logic             FL_DQ_OE,
    input  wire logic [15:0] FL_DQ_I,
    output logic             FL_CE_N,
    output logic             FL_WE_N,
    output logic             FL_OE_N,
    output logic             ACC_HV_EN
);
    // ------------------------------------------------------------------
    // pin synchroniser for read data
    // ------------------------------------------------------------------
    logic [15:0] dq_s1_reg, dq_s2_reg;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dq_s1_reg <= 16'h0000;
            dq_s2_reg <= 16'h0000;
        end else begin
            dq_s1_reg <= FL_DQ_I;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_READ}
        state_t;
    state_t                        state_reg, state_next;
    flash_ctl_pkg::flash_cycle_t   seq_reg [6];
    flash_ctl_pkg::flash_cycle_t   seq_next [6];
    logic [2:0]                    idx_reg, idx_next, len_reg, len_next;
    logic [flash_ctl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [23:0]                   addr_reg, addr_next;
    logic [15:0]                   wdat_reg, wdat_next, rdat_reg, rdat_next;
    logic                          acc_reg, acc_next, ack_reg, ack_next;
    logic [31:0]                   dout_reg, dout_next;
    logic                          go;

    // build one write cycle
    function automatic flash_ctl_pkg::flash_cycle_t wr(
        input logic [23:0] a, input logic [7:0] d);
        wr = '{rd: 1'b0, addr: a, data: {8'h00, d}};
    endfunction : wr

    // sector base of an address: bits below the sector field cleared
    function automatic logic [23:0] sector_addr(input logic [23:0] a);
        sector_addr = {a[23:flash_ctl_pkg::SECTOR_LSB],
                       {flash_ctl_pkg::SECTOR_LSB{1'b0}}};
    endfunction : sector_addr

    assign go = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_reg
                && WB_ADR_I == flash_ctl_pkg::REG_CMD && WB_SEL_I[0];

    // next-state: register writes start sequences; long ops run on device
    always_comb begin
        state_next = state_reg;
        seq_next   = seq_reg;
        idx_next   = idx_reg;
        len_next   = len_reg;
        cnt_next   = cnt_reg;
        addr_next  = addr_reg;
        wdat_next  = wdat_reg;
        rdat_next  = rdat_reg;
        acc_next   = acc_reg;
        ack_next   = 1'b0;
        dout_next  = dout_reg;
        if (WB_CYC_I && WB_STB_I && !ack_reg) begin
            // busy writes to REG_CMD are still acked but dropped
            ack_next = 1'b1;
            if (WB_WE_I) begin
                unique case (WB_ADR_I)
                    flash_ctl_pkg::REG_ADDR: addr_next = WB_DAT_I[23:0];
                    flash_ctl_pkg::REG_DATA: wdat_next = WB_DAT_I[15:0];
                    // the pin may not move under a running cycle
                    flash_ctl_pkg::REG_STATUS: if (state_reg == S_IDLE)
                        acc_next = WB_DAT_I[flash_ctl_pkg::STAT_ACC];
                    default: ;
                endcase
            end else begin
                unique case (WB_ADR_I)
                    flash_ctl_pkg::REG_ADDR:   dout_next = {8'h00, addr_reg};
                    flash_ctl_pkg::REG_DATA:   dout_next = {16'h0000, wdat_reg};
                    flash_ctl_pkg::REG_STATUS: dout_next =
                        {30'h0, acc_reg, state_reg != S_IDLE};
                    flash_ctl_pkg::REG_RDATA:  dout_next = {16'h0000, rdat_reg};
                    default:                   dout_next = 32'h0000_0000;
                endcase
            end
        end
        unique case (state_reg)
            S_IDLE: if (go) begin
                idx_next = 3'd0;
                cnt_next = '0;
                state_next = S_SETUP;
                seq_next[0] = wr(flash_ctl_pkg::ADDR_UNLOCK1,
                                 flash_ctl_pkg::CMD_UNLOCK1);
                seq_next[1] = wr(flash_ctl_pkg::ADDR_UNLOCK2,
                                 flash_ctl_pkg::CMD_UNLOCK2);
                seq_next[2] = wr(flash_ctl_pkg::ADDR_UNLOCK1,
                                 flash_ctl_pkg::CMD_SETUP);
                seq_next[3] = seq_next[0];
                seq_next[4] = seq_next[1];
                seq_next[5] = wr(flash_ctl_pkg::ADDR_UNLOCK1,
                                 flash_ctl_pkg::CMD_CHIP);
                len_next = 3'd6;
                unique case (flash_ctl_pkg::op_t'(WB_DAT_I[2:0]))
                    flash_ctl_pkg::OP_CHIP_ERASE: ;
                    flash_ctl_pkg::OP_SECTOR_ERASE:
                        seq_next[5] = wr(sector_addr(addr_reg),
                                         flash_ctl_pkg::CMD_SECTOR);
                    flash_ctl_pkg::OP_ADD_SECTOR: begin
                        seq_next[0] = wr(sector_addr(addr_reg),
                                         flash_ctl_pkg::CMD_SECTOR);
                        len_next = 3'd1;
                    end
                    flash_ctl_pkg::OP_SUSPEND: begin
                        seq_next[0] = wr(24'h000000, flash_ctl_pkg::CMD_SUSPEND);
                        len_next = 3'd1;
                    end
                    flash_ctl_pkg::OP_RESUME: begin
                        seq_next[0] = wr(24'h000000, flash_ctl_pkg::CMD_RESUME);
                        len_next = 3'd1;
                    end
                    flash_ctl_pkg::OP_BYP_PROGRAM: begin
                        seq_next[0] = wr(24'h000000, flash_ctl_pkg::CMD_BYP_PROG);
                        seq_next[1] = '{rd: 1'b0, addr: addr_reg, data: wdat_reg};
                        len_next = 3'd2;
                    end
                    flash_ctl_pkg::OP_READ: begin
                        seq_next[0] = '{rd: 1'b1, addr: addr_reg, data: 16'h0};
                        len_next = 3'd1;
                    end
                    default: state_next = S_IDLE;
                endcase
                // high voltage only ever backs a bypass program
                if (acc_reg && flash_ctl_pkg::op_t'(WB_DAT_I[2:0])
                        != flash_ctl_pkg::OP_BYP_PROGRAM) begin
                    state_next = S_IDLE;
                end
            end
            S_SETUP: begin
                state_next = seq_reg[idx_reg].rd ? S_READ : S_LOW;
                cnt_next = '0;
            end
            S_LOW, S_READ: begin
                cnt_next = cnt_reg + 1'b1;
                // stretched by the synchroniser depth so a read lands
                if (cnt_reg == flash_ctl_pkg::CNT_W'(flash_ctl_pkg::WE_LOW_CYC
                        + flash_ctl_pkg::SYNC_STAGES)) begin
                    if (state_reg == S_READ) rdat_next = dq_s2_reg;
                    cnt_next = '0;
                    state_next = S_HIGH;
                end
            end
            S_HIGH: begin
                // gap kept far below the acceptance window
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == flash_ctl_pkg::CNT_W'(flash_ctl_pkg::WE_HIGH_CYC))
                begin
                    cnt_next = '0;
                    if (idx_reg + 3'd1 == len_reg) state_next = S_IDLE;
                    else begin
                        idx_next = idx_reg + 3'd1;
                        state_next = S_SETUP;
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // registers only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= S_IDLE;
            for (int i = 0; i < 6; i++) seq_reg[i] <= '0;
            idx_reg <= 3'd0;
            len_reg <= 3'd0;
            cnt_reg <= '0;
            addr_reg <= 24'h000000;
            wdat_reg <= 16'h0000;
            rdat_reg <= 16'h0000;
            acc_reg <= 1'b0;
            ack_reg <= 1'b0;
            dout_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            seq_reg <= seq_next;
            idx_reg <= idx_next;
            len_reg <= len_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdat_reg <= wdat_next;
            rdat_reg <= rdat_next;
            acc_reg <= acc_next;
            ack_reg <= ack_next;
            dout_reg <= dout_next;
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    assign WB_ACK_O  = ack_reg;
    assign WB_DAT_O  = dout_reg;
    assign FL_ADDR   = seq_reg[idx_reg].addr;
    assign FL_DQ_O   = seq_reg[idx_reg].data;
    assign FL_DQ_OE  = state_reg inside {S_SETUP, S_LOW, S_HIGH}
                       && !seq_reg[idx_reg].rd;
    assign FL_CE_N   = !(state_reg inside {S_SETUP, S_LOW, S_READ, S_HIGH});
    assign FL_WE_N   = state_reg != S_LOW;
    assign FL_OE_N   = state_reg != S_READ;
    assign ACC_HV_EN = acc_reg;
endmodule : flash_erase_ctl

// ---- test/flash_erase_ctl_checker.sv ----
// port checker for the flash erase controller
module flash_erase_ctl_checker (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic [23:0] FL_ADDR,
    input wire logic [15:0] FL_DQ_O,
    input wire logic        FL_DQ_OE,
    input wire logic        FL_CE_N,
    input wire logic        FL_WE_N,
    input wire logic        FL_OE_N,
    input wire logic        ACC_HV_EN
);
    // ------------
    // bus timing
    // ------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ack is one pulse, one cycle after the request is taken
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    a_ack_due: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing");
    // write strobe widths keep the minimum pulse and recovery times
    a_we_width: assert property
        ($fell(FL_WE_N) |-> (!FL_WE_N)[*5] ##[1:12] FL_WE_N)
        else $error("write pulse width");
    a_we_recover: assert property ($rose(FL_WE_N) |-> FL_WE_N[*3])
        else $error("write recovery short");
    a_write_hold: assert property
        (!FL_WE_N |-> !FL_CE_N && FL_DQ_OE && $stable(FL_ADDR)
            && $stable(FL_DQ_O)) else $error("write cycle not held");
    // a read never fights the device for the data lines
    a_read_clean: assert property
        (!FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE)
        else $error("read overlaps drive");
    a_oe_width: assert property
        ($fell(FL_OE_N) |-> (!FL_OE_N)[*5] ##[1:12] FL_OE_N)
        else $error("read pulse width");
    a_acc_steady: assert property (!FL_WE_N |-> $stable(ACC_HV_EN))
        else $error("high voltage moved in a write");
    c_acc_write: cover property ($fell(FL_WE_N) && ACC_HV_EN);
    c_read: cover property ($fell(FL_OE_N));
    c_ack: cover property (WB_ACK_O);
endmodule : flash_erase_ctl_checker

bind flash_erase_ctl flash_erase_ctl_checker i_chk (.*);

// ---- test/flash_dev_model.sv ----
// behavioural model of the flash device on the far side of the bus
module flash_dev_model #(
    parameter int WIN_NS   = 50000,
    parameter int ERASE_NS = 100000
) (
    input  wire logic [23:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        acc_hv,
    output logic      [15:0] rdata,
    output logic      [2:0]  mode,
    output int               sectors,
    output int               progs
);
    timeunit 1ns;
    timeprecision 1ns;
    // modes: 0 read, 1 window, 2 sector erase, 3 chip erase, 4 suspended
    logic [7:0]   seq [5] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
    logic [511:0] sel = '0;
    logic [15:0]  last = 16'h0000;
    logic         tog = 1'b0;
    logic         byp = 1'b0;
    int           step = 0;
    realtime      t_win, t_done;
    initial mode = 3'h0;
    initial sectors = 0;
    initial progs = 0;
    // ---------------
    // command decode
    // ---------------
    // data is taken on the rising write strobe
    always @(posedge we_n) if (!ce_n) begin
        if (mode == 3'h2 && wdata[7:0] == 8'hB0) begin
            mode = 3'h4;
        end else if (mode == 3'h2 || mode == 3'h3) begin
            step = 0; // ignored while erasing
        end else if (byp) begin
            progs++; // program is instant, mode kept
            byp = 1'b0;
        end else if (acc_hv && wdata[7:0] == 8'hA0) begin
            byp = 1'b1; // high voltage implies bypass
        end else if (mode == 3'h1 && wdata[7:0] == 8'hB0) begin
            mode = 3'h4;
        end else if (mode == 3'h1 && wdata[7:0] == 8'h30) begin
            sel[addr[23:15]] = 1'b1;
            sectors++;
            t_win = $realtime;
        end else if (mode == 3'h1) begin
            mode = 3'h0;
        end else if (mode == 3'h4 && wdata[7:0] == 8'hB0) begin
            step = 0; // programs end at once: nothing to halt
        end else if (mode == 3'h4 && wdata[7:0] == 8'h30) begin
            mode = 3'h2; // unfinished steps start over
            t_done = $realtime + ERASE_NS;
        end else if (step < 5 && wdata[7:0] == seq[step] && addr[10:0]
                     == (step % 3 == 1 ? 11'h2AA : 11'h555)) begin
            step++; // unlock prefixes count in suspend too
        end else if (step == 5 && wdata[7:0] == 8'h10) begin
            mode = 3'h3;
            t_done = $realtime + ERASE_NS;
            step = 0;
        end else if (step == 5 && wdata[7:0] == 8'h30) begin
            mode = 3'h1;
            sel[addr[23:15]] = 1'b1;
            sectors = 1;
            t_win = $realtime;
            step = 0;
        end else step = 0;
    end
    // timers are polled coarsely; 100 ns is far below the window
    always #100 begin
        if (mode == 3'h1 && $realtime - t_win >= WIN_NS) begin
            mode = 3'h2;
            t_done = $realtime + ERASE_NS;
        end
        if ((mode == 3'h2 || mode == 3'h3) && $realtime >= t_done) begin
            mode = 3'h0;
            sel = '0;
        end
    end
    // status replaces data while busy; a released bus shows no stale value
    always @(negedge oe_n) tog = ~tog;
    always @* begin
        if (!ce_n && !oe_n) begin
            last = (mode inside {3'h1, 3'h2, 3'h3}
                    || (mode == 3'h4 && sel[addr[23:15]]))
                 ? {8'h00, mode == 3'h4, mode inside {3'h2, 3'h3} && tog,
                    2'b00, mode != 3'h1, tog, 2'b00}
                 : 16'hFFFF;
            rdata = last;
        end else rdata = ~last;
    end
endmodule : flash_dev_model

// ---- test/flash_erase_ctl_tb.sv ----
// self-checking bench for the flash erase controller
module flash_erase_ctl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        WB_CYC_I = 1'b0;
    logic        WB_STB_I = 1'b0;
    logic        WB_WE_I = 1'b0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [3:0]  WB_SEL_I = 4'hF;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
    logic [23:0] FL_ADDR;
    logic [15:0] FL_DQ_O, FL_DQ_I;
    logic        WB_ACK_O, FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N, ACC_HV_EN;
    logic [2:0]  mode;
    int          sectors, progs, failures = 0, checks = 0;

    initial forever #5 CLK = ~CLK;
    flash_erase_ctl i_dut (.*);
    flash_dev_model i_flash (.addr(FL_ADDR), .wdata(FL_DQ_O), .ce_n(FL_CE_N),
        .we_n(FL_WE_N), .oe_n(FL_OE_N), .acc_hv(ACC_HV_EN), .rdata(FL_DQ_I),
        .mode(mode), .sectors(sectors), .progs(progs));
    // -------------
    // bus helpers
    // -------------
    // request held until ack is sampled at a rising edge; data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        do @(posedge CLK); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask : wb
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic op(input logic [2:0] o);
        wb(1'b1, flash_ctl_pkg::REG_CMD, {29'h0, o});
        do wb(1'b0, flash_ctl_pkg::REG_STATUS, 32'h0);
        while (q[0] !== 1'b0);
    endtask : op
    task automatic fr(input logic [23:0] a);
        wb(1'b1, flash_ctl_pkg::REG_ADDR, {8'h00, a});
        op(3'h6);
        wb(1'b0, flash_ctl_pkg::REG_RDATA, 32'h0);
    endtask : fr
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // a hang counts against the run
    initial begin
        #600000;
        failures++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        wb(1'b0, 8'h3C, 32'h0);
        chk("unmapped", 32'h0, q);
        // chip erase shrugs off a suspend
        op(3'h0);
        chk("chip mode", 32'h3, 32'(mode));
        fr(24'h000000);
        chk("polling", 32'h0, 32'(q[7]));
        op(3'h3);
        chk("chip mode", 32'h3, 32'(mode));
        do fr(24'h000000); while (q[7] !== 1'b1);
        chk("array", 32'hFFFF, 32'(q[15:0]));
        // two sectors, suspend in the window, program another sector
        wb(1'b1, flash_ctl_pkg::REG_ADDR, 32'h0001_8000);
        op(3'h1);
        chk("window", 32'h1, 32'(mode));
        fr(24'h000000);
        chk("timer", 32'h0, 32'(q[3]));
        wb(1'b1, flash_ctl_pkg::REG_ADDR, 32'h007F_8000);
        op(3'h2);
        chk("sectors", 32'h2, 32'(sectors));
        op(3'h3);
        chk("suspended", 32'h4, 32'(mode));
        fr(24'h7F8000);
        chk("status read", 32'h1, 32'(q[15:7]));
        fr(24'h400000);
        chk("free read", 32'hFFFF, 32'(q[15:0]));
        wb(1'b1, flash_ctl_pkg::REG_STATUS, 32'h2);
        chk("accel", 32'h1, 32'(ACC_HV_EN));
        op(3'h4);
        chk("refused", 32'h4, 32'(mode));
        wb(1'b1, flash_ctl_pkg::REG_DATA, 32'h1234);
        op(3'h5);
        chk("programs", 32'h1, 32'(progs));
        chk("suspended", 32'h4, 32'(mode));
        wb(1'b1, flash_ctl_pkg::REG_STATUS, 32'h0);
        op(3'h4);
        op(3'h4);
        chk("erasing", 32'h2, 32'(mode));
        fr(24'h000000);
        chk("timer", 32'h1, 32'(q[3]));
        do fr(24'h000000); while (q[7] !== 1'b1);
        chk("read mode", 32'h0, 32'(mode));
        close_out();
    end
endmodule : flash_erase_ctl_tb
